// ==== logic/wdcu_pkg.sv ====
/*
 * constants of the watchdog control unit: register map, field
 * positions, reset values, unlock keys and timing counts.
 * assumes a 20 MHz bus clock and a slow watchdog source clock.
 */
`default_nettype none

package wdcu_pkg;

	// ********************************************************
	// register map (byte addresses, one word each)
	// ********************************************************
	localparam int           WDCU_ADDR_W     = 12;
	localparam logic [11:0]  WDCU_CTRL_IDX   = 12'h0aa;
	localparam logic [11:0]  WDCU_CTRL_ADDR  = {WDCU_CTRL_IDX[9:0], 2'b00};
	localparam logic [11:0]  WDCU_CFG_ADDR   = 12'h000;
	localparam logic [11:0]  WDCU_UNLK_ADDR  = 12'h004;
	localparam logic [11:0]  WDCU_ISTA_ADDR  = 12'h008;
	localparam logic [11:0]  WDCU_IEN_ADDR   = 12'h00c;
	localparam logic [11:0]  WDCU_ICLR_ADDR  = 12'h010;
	localparam logic [11:0]  WDCU_CNT_ADDR   = 12'h014;

	// ********************************************************
	// watchdog_control fields
	// ********************************************************
	localparam int           WDCU_RUN_BIT    = 7;
	localparam int           WDCU_CLR_BIT    = 6;
	localparam int           WDCU_OVF_BIT    = 5;
	localparam int           WDCU_LP_BIT     = 4;
	localparam int           WDCU_RSTF_BIT   = 3;
	localparam int           WDCU_PS_LSB     = 0;
	localparam int           WDCU_PS_W       = 3;
	localparam logic [2:0]   WDCU_PS_RESET   = 3'h7;

	// ********************************************************
	// configuration word fields
	// ********************************************************
	localparam int           WDCU_CFGEN_LSB  = 0;
	localparam int           WDCU_CFGEN_W    = 4;
	localparam logic [3:0]   WDCU_CFGEN_GPT  = 4'hf;
	localparam logic [3:0]   WDCU_CFGEN_RST  = 4'h0;
	localparam int           WDCU_DIV_LSB    = 8;
	localparam int           WDCU_DIV_W      = 8;
	localparam logic [7:0]   WDCU_DIV_RESET  = 8'h00;

	// ********************************************************
	// unlock keys and interrupt bits
	// ********************************************************
	localparam logic [7:0]   WDCU_KEY_FIRST  = 8'haa;
	localparam logic [7:0]   WDCU_KEY_SECOND = 8'h55;
	localparam int           WDCU_IRQ_W      = 2;
	localparam int           WDCU_IRQ_OVF    = 0;
	localparam int           WDCU_IRQ_REFUSE = 1;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int           WDCU_CLK_PERIOD_NS = 50;
	localparam int           WDCU_SRC_PERIOD_NS = 100000;
	localparam int           WDCU_SRC_CYCLES    = WDCU_SRC_PERIOD_NS / WDCU_CLK_PERIOD_NS;
	localparam int           WDCU_CNT_W         = 6;

	typedef enum logic [2:0] {
		WDCU_LOCKED = 3'b001,
		WDCU_HALF   = 3'b010,
		WDCU_OPEN   = 3'b100
	} wdcu_unlock_t;

endpackage : wdcu_pkg

`default_nettype wire

// ==== logic/wdcu_watchdog.sv ====
/*
 * watchdog control unit: protected control word, prescaled counter,
 * overflow and reset-cause flags, interrupt status, AHB-Lite slave.
 * assumes hresetn is the power-on reset and warm_reset a one-cycle
 * pulse for every other chip reset, both on hclk.
 */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module wdcu_watchdog
	import wdcu_pkg::*;
#(
	parameter int CNT_W      = WDCU_CNT_W,
	parameter int SRC_CYCLES = WDCU_SRC_CYCLES
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// chip power and reset
	input  wire logic        cpu_idle,
	input  wire logic        cpu_power_down,
	input  wire logic        warm_reset,
	output logic             dog_reset_req,
	// interrupt
	output logic             irq
);

	// ********************************************************
	// bus address phase
	// ********************************************************
	logic                    a_wr;
	logic                    a_rd;
	logic [WDCU_ADDR_W-1:0]  a_addr;
	logic                    take;

	assign take = hsel & hready & htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr   <= 1'b0;
			a_rd   <= 1'b0;
			a_addr <= '0;
		end else begin
			a_wr   <= take & hwrite;
			a_rd   <= take & ~hwrite;
			a_addr <= haddr[WDCU_ADDR_W-1:0];
		end
	end

	// zero-wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ********************************************************
	// timed access unlock
	// ********************************************************
	wdcu_unlock_t            unlock;
	logic                    wr_ctrl;
	logic                    wr_ctrl_ok;
	logic                    wr_unlk;

	assign wr_ctrl    = a_wr & (a_addr == WDCU_CTRL_ADDR);
	assign wr_unlk    = a_wr & (a_addr == WDCU_UNLK_ADDR);
	assign wr_ctrl_ok = wr_ctrl & (unlock == WDCU_OPEN);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			unlock <= WDCU_LOCKED;
		end else if (warm_reset) begin
			unlock <= WDCU_LOCKED;
		end else if (a_wr) begin
			// any write other than the next key step closes the window
			unique case (unlock)
				WDCU_LOCKED: begin
					unlock <= (wr_unlk && hwdata[7:0] == WDCU_KEY_FIRST) ? WDCU_HALF : WDCU_LOCKED;
				end
				WDCU_HALF: begin
					unlock <= (wr_unlk && hwdata[7:0] == WDCU_KEY_SECOND) ? WDCU_OPEN : WDCU_LOCKED;
				end
				WDCU_OPEN: begin
					unlock <= WDCU_LOCKED;
				end
				default: begin
					unlock <= WDCU_LOCKED;
				end
			endcase
		end
	end

	// ********************************************************
	// configuration word
	// ********************************************************
	logic [WDCU_CFGEN_W-1:0] config_enable_field;
	logic [WDCU_DIV_W-1:0]   system_clock_divider;
	logic                    gp_mode;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_enable_field  <= WDCU_CFGEN_RST;
			system_clock_divider <= WDCU_DIV_RESET;
		end else if (a_wr && a_addr == WDCU_CFG_ADDR) begin
			config_enable_field  <= hwdata[WDCU_CFGEN_LSB +: WDCU_CFGEN_W];
			system_clock_divider <= hwdata[WDCU_DIV_LSB +: WDCU_DIV_W];
		end
	end

	assign gp_mode = (config_enable_field == WDCU_CFGEN_GPT);

	// ********************************************************
	// watchdog control fields
	// ********************************************************
	logic                    timer_run_bit;
	logic                    count_clear_bit;
	logic                    overflow_flag;
	logic                    low_power_run_bit;
	logic                    dog_reset_flag;
	logic [WDCU_PS_W-1:0]    clock_prescale_sel;
	logic                    src_tick;
	logic                    wd_tick;
	logic                    overflow;
	logic                    reset_fire;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_run_bit     <= 1'b0;
			low_power_run_bit <= 1'b0;
		end else if (warm_reset) begin
			timer_run_bit     <= 1'b0;
			low_power_run_bit <= 1'b0;
		end else if (wr_ctrl_ok) begin
			timer_run_bit     <= hwdata[WDCU_RUN_BIT];
			low_power_run_bit <= hwdata[WDCU_LP_BIT];
		end
	end

	// pending clear completes on the next watchdog source edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_clear_bit <= 1'b0;
		end else if (warm_reset) begin
			count_clear_bit <= 1'b0;
		end else if (wr_ctrl_ok && hwdata[WDCU_CLR_BIT]) begin
			count_clear_bit <= 1'b1;
		end else if (src_tick) begin
			count_clear_bit <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overflow_flag <= 1'b0;
		end else if (warm_reset) begin
			overflow_flag <= 1'b0;
		end else if (overflow) begin
			overflow_flag <= 1'b1;
		end else if (wr_ctrl_ok) begin
			overflow_flag <= hwdata[WDCU_OVF_BIT];
		end
	end

	// warm_reset leaves this flag alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dog_reset_flag <= 1'b0;
		end else if (reset_fire) begin
			dog_reset_flag <= 1'b1;
		end else if (wr_ctrl_ok) begin
			dog_reset_flag <= hwdata[WDCU_RSTF_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_prescale_sel <= WDCU_PS_RESET;
		end else if (wr_ctrl_ok) begin
			clock_prescale_sel <= hwdata[WDCU_PS_LSB +: WDCU_PS_W];
		end
	end

	// ********************************************************
	// watchdog source clock enable
	// ********************************************************
	logic [$clog2(SRC_CYCLES)-1:0] src_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_cnt <= '0;
		end else if (src_cnt == ($clog2(SRC_CYCLES))'(SRC_CYCLES - 1)) begin
			src_cnt <= '0;
		end else begin
			src_cnt <= src_cnt + 1'b1;
		end
	end

	assign src_tick = (src_cnt == ($clog2(SRC_CYCLES))'(SRC_CYCLES - 1));

	// ********************************************************
	// prescaler and counter
	// ********************************************************
	logic                    running;
	logic [7:0]              pre_cnt;
	logic [CNT_W-1:0]        wd_cnt;

	// sel 0 -> 1/1, sel n -> 1/2^(n+1), sel 7 -> 1/256
	function automatic logic [7:0] wdcu_pre_mask(input logic [2:0] sel);
		logic [8:0] m;
		m = 9'h000;
		if (sel != 3'h0) begin
			// widen before the add so that sel 7 shifts by 8, not by 0
			m = (9'h001 << ({1'b0, sel} + 4'h1)) - 9'h001;
		end
		return m[7:0];
	endfunction : wdcu_pre_mask

	assign running = gp_mode
		? (timer_run_bit & (low_power_run_bit | ~(cpu_idle | cpu_power_down)))
		: 1'b1;
	assign wd_tick  = src_tick & running & ~count_clear_bit
		& ((pre_cnt & wdcu_pre_mask(clock_prescale_sel)) == wdcu_pre_mask(clock_prescale_sel));
	assign overflow = wd_tick & (&wd_cnt);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt <= '0;
			wd_cnt  <= '0;
		end else if (warm_reset) begin
			pre_cnt <= '0;
			wd_cnt  <= '0;
		end else if (src_tick && count_clear_bit) begin
			pre_cnt <= '0;
			wd_cnt  <= '0;
		end else if (src_tick && running) begin
			pre_cnt <= pre_cnt + 1'b1;
			if (wd_tick) begin
				wd_cnt <= wd_cnt + 1'b1;
			end
		end
	end

	// ********************************************************
	// time-out reset request
	// ********************************************************
	assign reset_fire = overflow & ~gp_mode
		& ~(cpu_power_down & (system_clock_divider != WDCU_DIV_RESET));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dog_reset_req <= 1'b0;
		end else begin
			dog_reset_req <= reset_fire;
		end
	end

	// ********************************************************
	// interrupt status, enable, clear
	// ********************************************************
	logic [WDCU_IRQ_W-1:0]   int_status;
	logic [WDCU_IRQ_W-1:0]   int_enable;
	logic [WDCU_IRQ_W-1:0]   int_event;
	logic [WDCU_IRQ_W-1:0]   int_clear;

	assign int_event[WDCU_IRQ_OVF]    = overflow;
	assign int_event[WDCU_IRQ_REFUSE] = wr_ctrl & ~wr_ctrl_ok;
	assign int_clear = (a_wr && a_addr == WDCU_ICLR_ADDR) ? hwdata[WDCU_IRQ_W-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status <= '0;
		end else begin
			// event wins over a clear in the same cycle
			int_status <= (int_status & ~int_clear) | int_event;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_enable <= '0;
		end else if (a_wr && a_addr == WDCU_IEN_ADDR) begin
			int_enable <= hwdata[WDCU_IRQ_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((int_status & ~int_clear) | int_event) & int_enable);
		end
	end

	// ********************************************************
	// read data, sampled in the address phase
	// ********************************************************
	logic [31:0]             next_hrdata;

	always_comb begin
		next_hrdata = 32'h0000_0000;
		unique case (haddr[WDCU_ADDR_W-1:0])
			WDCU_CTRL_ADDR: begin
				next_hrdata[WDCU_RUN_BIT]  = timer_run_bit;
				next_hrdata[WDCU_CLR_BIT]  = count_clear_bit;
				next_hrdata[WDCU_OVF_BIT]  = overflow_flag;
				next_hrdata[WDCU_LP_BIT]   = low_power_run_bit;
				next_hrdata[WDCU_RSTF_BIT] = dog_reset_flag;
				next_hrdata[WDCU_PS_LSB +: WDCU_PS_W] = clock_prescale_sel;
			end
			WDCU_CFG_ADDR: begin
				next_hrdata[WDCU_CFGEN_LSB +: WDCU_CFGEN_W] = config_enable_field;
				next_hrdata[WDCU_DIV_LSB +: WDCU_DIV_W]     = system_clock_divider;
			end
			WDCU_ISTA_ADDR: begin
				next_hrdata[WDCU_IRQ_W-1:0] = int_status;
			end
			WDCU_IEN_ADDR: begin
				next_hrdata[WDCU_IRQ_W-1:0] = int_enable;
			end
			WDCU_CNT_ADDR: begin
				next_hrdata[CNT_W-1:0] = wd_cnt;
			end
			default: begin
				next_hrdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

endmodule : wdcu_watchdog

`default_nettype wire

// ==== tb/tb_watchdog_control_unit.sv ====
/*
 * self-checking bench of the watchdog unit over ahb-lite.
 * assumes a short source tick period set through SRC_CYCLES.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_watchdog_control_unit
	import wdcu_pkg::*;
;
	localparam int SRC = 16;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        cpu_idle, cpu_power_down, warm_reset, dog_reset_req, irq;
	logic [31:0] haddr, hwdata, hrdata, v, c0;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire logic   hready;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          n_req = 0;
	int          r;
	assign hready = hreadyout;

	wdcu_watchdog #(.SRC_CYCLES(SRC)) wdcu_watchdog_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle),
		.cpu_power_down(cpu_power_down), .warm_reset(warm_reset), .dog_reset_req(dog_reset_req), .irq(irq));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) if (dog_reset_req === 1'b1) n_req <= n_req + 1;

	// ********************************************************
	// shared tasks
	// ********************************************************
	task automatic close_out;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			close_out();
		end
	endtask : wait_rdy
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		v = hrdata;
	endtask : bus
	task automatic rd(input logic [11:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic ctl(input logic [31:0] d);
		bus(1'b1, WDCU_UNLK_ADDR, {24'h0, WDCU_KEY_FIRST});
		bus(1'b1, WDCU_UNLK_ADDR, {24'h0, WDCU_KEY_SECOND});
		bus(1'b1, WDCU_CTRL_ADDR, d);
	endtask : ctl
	task automatic gap(input int n);
		repeat (n) @(posedge hclk);
	endtask : gap
	task automatic clr_wait;
		ctl(32'h40);
		rd(WDCU_CTRL_ADDR);
		for (int n = 0; n < 10 && v[WDCU_CLR_BIT] !== 1'b0; n++) rd(WDCU_CTRL_ADDR);
		check(v[WDCU_CLR_BIT], 0);
		if (v[WDCU_CLR_BIT] !== 1'b0) close_out();
		rd(WDCU_CNT_ADDR);
		check(v, 0);
	endtask : clr_wait

	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_refused;
		rd(WDCU_CTRL_ADDR);
		check(v, 32'h7);
		rd(12'h040);
		check(v, 0);
		bus(1'b1, WDCU_IEN_ADDR, 32'h2);
		bus(1'b1, WDCU_CTRL_ADDR, 32'h80);
		bus(1'b1, WDCU_UNLK_ADDR, {24'h0, WDCU_KEY_FIRST});
		bus(1'b1, WDCU_UNLK_ADDR, {24'h0, WDCU_KEY_SECOND});
		bus(1'b1, WDCU_CFG_ADDR, 32'h0);
		bus(1'b1, WDCU_CTRL_ADDR, 32'h80);
		rd(WDCU_CTRL_ADDR);
		check(v, 32'h7);
		rd(WDCU_ISTA_ADDR);
		check(v, 32'h2);
		check({31'h0, irq}, 1);
		bus(1'b1, WDCU_ICLR_ADDR, 32'h2);
		rd(WDCU_ISTA_ADDR);
		check({v[30:0], irq}, 0);
	endtask : t_refused
	task automatic t_gpt;
		bus(1'b1, WDCU_CFG_ADDR, {28'h0, WDCU_CFGEN_GPT});
		ctl(32'h80);
		gap(SRC * 5);
		ctl(32'h00);
		rd(WDCU_CNT_ADDR);
		c0 = v;
		check({31'h0, v == 0}, 0);
		gap(SRC * 3);
		rd(WDCU_CNT_ADDR);
		check(v, c0);
		clr_wait();
		cpu_idle <= 1'b1;
		ctl(32'h80);
		gap(SRC * 4);
		rd(WDCU_CNT_ADDR);
		check(v, 0);
		cpu_idle <= 1'b0;
		cpu_power_down <= 1'b1;
		ctl(32'h90);
		gap(SRC * 4);
		rd(WDCU_CNT_ADDR);
		check({31'h0, v == 0}, 0);
		cpu_power_down <= 1'b0;
		clr_wait();
	endtask : t_gpt
	task automatic t_overflow;
		r = n_req;
		ctl(32'h80);
		gap(((1 << WDCU_CNT_W) + 4) * SRC);
		rd(WDCU_CTRL_ADDR);
		check(v, 32'ha0);
		rd(WDCU_ISTA_ADDR);
		check(v, 32'h1);
		gap(SRC * 8);
		rd(WDCU_CTRL_ADDR);
		check(v[WDCU_OVF_BIT], 1);
		check(n_req, r);
		ctl(32'h00);
		rd(WDCU_CTRL_ADDR);
		check(v, 0);
	endtask : t_overflow
	task automatic t_dog_reset;
		r = n_req;
		bus(1'b1, WDCU_CFG_ADDR, 32'h0);
		for (int n = 0; n < 80 * SRC && n_req == r; n++) @(posedge hclk);
		check({31'h0, n_req > r}, 1);
		if (n_req == r) close_out();
		warm_reset <= 1'b1;
		@(posedge hclk);
		warm_reset <= 1'b0;
		rd(WDCU_CTRL_ADDR);
		check(v, 32'h8);
		hresetn <= 1'b0;
		gap(3);
		hresetn <= 1'b1;
		rd(WDCU_CTRL_ADDR);
		check(v, 32'h7);
	endtask : t_dog_reset
	// power-on prescale of 1/256: first count lands after 256 source ticks
	task automatic t_prescale;
		gap(200 * SRC);
		rd(WDCU_CNT_ADDR);
		check(v, 0);
		gap(100 * SRC);
		rd(WDCU_CNT_ADDR);
		check(v, 1);
	endtask : t_prescale
	task automatic t_pd_divider;
		r = n_req;
		bus(1'b1, WDCU_CFG_ADDR, 32'h100);
		ctl(32'h00);
		cpu_power_down <= 1'b1;
		gap(70 * SRC);
		check(n_req, r);
		rd(WDCU_CTRL_ADDR);
		check(v, 32'h20);
		cpu_power_down <= 1'b0;
	endtask : t_pd_divider

	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, cpu_idle, cpu_power_down, warm_reset} = 5'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'h2;
		gap(3);
		hresetn <= 1'b1;
		t_refused();
		t_gpt();
		t_overflow();
		t_dog_reset();
		t_prescale();
		t_pd_divider();
		close_out();
	end
endmodule : tb_watchdog_control_unit

`default_nettype wire

// ==== tb/wdcu_checker_assertions.sv ====
/*
 * port checker of the watchdog unit: bus answers and reset request.
 * assumes hready is tied to hreadyout and hresetn is power-on.
 */
`timescale 1ns/100ps
`default_nettype none

module wdcu_checker
	import wdcu_pkg::*;
#(
	parameter int CNT_W = WDCU_CNT_W
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	// chip reset
	input  wire logic        warm_reset,
	input  wire logic        dog_reset_req
);
	// ********************************************************
	// properties
	// ********************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rd_at(a);
		hsel && hready && htrans[1] && !hwrite && haddr[11:0] == a;
	endsequence

	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("error response");
	AST_READY_UP: assert property ($past(hresetn) |-> hreadyout)
		else $error("wait state inserted");
	AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	AST_UNMAPPED_ZERO: assert property (rd_at(12'h040) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_UPPER: assert property (rd_at(WDCU_CTRL_ADDR) |=> hrdata[31:8] == 24'h0)
		else $error("control word upper bits set");
	AST_STA_UPPER: assert property (rd_at(WDCU_ISTA_ADDR) |=> hrdata[31:2] == 30'h0)
		else $error("status upper bits set");
	AST_CNT_UPPER: assert property (rd_at(WDCU_CNT_ADDR) |=> (hrdata >> CNT_W) == 32'h0)
		else $error("count wider than counter");
	AST_REQ_PULSE: assert property (dog_reset_req |=> !dog_reset_req)
		else $error("reset request longer than one cycle");
	AST_WARM_QUIET: assert property (warm_reset |-> ##2 !dog_reset_req [*8])
		else $error("reset request right after warm reset");
endmodule : wdcu_checker

bind wdcu_watchdog wdcu_checker #(.CNT_W(CNT_W)) wdcu_checker_i (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.warm_reset(warm_reset), .dog_reset_req(dog_reset_req));

`default_nettype wire
